// ==== dv/flash_write_protection_logic_tb.sv ====
// self-checking bench for the write-protection block
// assumes the host model drives apb; busy counts shortened by parameter
`timescale 1ns/1ps
module flash_write_protection_logic_tb;
   import fwp_pkg::*;
   localparam int unsigned CYC = 6;
   localparam logic [31:0] SR_MASK = 32'h0004_5BFC;
   typedef struct packed {
      logic write_enable_cmd;
      logic [7:0] op;
      logic [31:0] sr;
      logic [19:0] tgt;
      fwp_result_t res;
   } fwp_row_t;
   logic pclk = 1'h0;
   logic presetn = 1'h0;
   logic psel, penable, pwrite, pready, pslverr;
   logic [PADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic wp_pin_n = 1'h1;
   logic quad_enable, write_in_progress, deep_power_down, array_go;
   int fails = 0;
   int checked = 0;
   int go_cnt = 0;
   logic [31:0] sec_exp = 32'h0;
   logic [31:0] v;
   // protection state evolves down the rows
   fwp_row_t rows [0:23] = '{
      '{1'h0, OP_PP, 32'h0, 20'h0, RES_IGNORED}, '{1'h1, OP_PP, 32'h0, 20'h0, RES_DONE},
      '{1'h1, OP_SE, 32'h0, 20'h0, RES_DONE}, '{1'h1, OP_BE32, 32'h0, 20'h0, RES_DONE},
      '{1'h1, OP_BE64, 32'h0, 20'h0, RES_DONE}, '{1'h1, OP_CE_A, 32'h0, 20'h0, RES_DONE},
      '{1'h1, OP_CE_B, 32'h0, 20'h0, RES_DONE}, '{1'h1, OP_SEC_ERASE, 32'h0, 20'h0, RES_DONE},
      '{1'h1, OP_SEC_PROG, 32'h0, 20'h0, RES_DONE}, '{1'h1, OP_STATUS_WRITE_CMD, 32'h4, 20'h0, RES_DONE},
      '{1'h1, OP_PP, 32'h0, 20'hF0000, RES_PROTECTED}, '{1'h1, OP_PP, 32'h0, 20'hEFF00, RES_DONE},
      '{1'h1, OP_CE_A, 32'h0, 20'h0, RES_PROTECTED}, '{1'h1, OP_STATUS_WRITE_CMD, 32'h24, 20'h0, RES_DONE},
      '{1'h1, OP_SE, 32'h0, 20'h0F000, RES_PROTECTED}, '{1'h1, OP_SE, 32'h0, 20'h10000, RES_DONE},
      '{1'h1, OP_STATUS_WRITE_CMD, 32'h44, 20'h0, RES_DONE}, '{1'h1, OP_SE, 32'h0, 20'hFF000, RES_PROTECTED},
      '{1'h1, OP_SE, 32'h0, 20'hFE000, RES_DONE}, '{1'h1, OP_STATUS_WRITE_CMD, 32'h14, 20'h0, RES_DONE},
      '{1'h1, OP_PP, 32'h0, 20'h0, RES_PROTECTED}, '{1'h1, OP_PP, 32'h0, 20'hFFF00, RES_PROTECTED},
      '{1'h1, OP_STATUS_WRITE_CMD, 32'h401C, 20'h0, RES_DONE}, '{1'h1, OP_CE_A, 32'h0, 20'h0, RES_DONE}
   };
   initial begin
      forever #25 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      if (array_go === 1'h1) go_cnt <= go_cnt + 1;
   end
   fwp_ctrl #(.PP_CYC(CYC), .SE_CYC(CYC), .BE32_CYC(CYC), .BE64_CYC(CYC), .CE_CYC(CYC),
         .SR_CYC(CYC)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
         .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
         .pready(pready), .pslverr(pslverr), .wp_pin_n(wp_pin_n), .quad_enable(quad_enable),
         .write_in_progress(write_in_progress), .deep_power_down(deep_power_down),
         .array_go(array_go));
   fwp_host_model host_u (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
         .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : summarize
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d,
         output logic [31:0] q);
      logic e, ok;
      host_u.xfer(w, a, d, q, e, ok);
      check("apb answer", {30'h0, ok, e}, 32'h2);
   endtask : acc
   task automatic wait_idle();
      logic [31:0] s;
      int n;
      n = 0;
      do begin
         acc(1'h0, OFS_STATUS, 32'h0, s);
         n++;
      end while (s[BIT_WIP] !== 1'h0 && n < 100);
      check("idle", {31'h0, s[BIT_WIP]}, 32'h0);
   endtask : wait_idle
   task automatic cmd(input logic [7:0] c);
      logic [31:0] q;
      acc(1'h1, OFS_CMD, {24'h0, c}, q);
      wait_idle();
   endtask : cmd
   task automatic op(input fwp_row_t r);
      logic [31:0] s;
      logic b;
      int g0;
      b = (r.res == RES_DONE);
      if (r.write_enable_cmd) cmd(OP_WRITE_ENABLE_CMD);
      acc(1'h1, OFS_SR_DATA, r.sr, s);
      acc(1'h1, OFS_TARGET, {12'h0, r.tgt}, s);
      g0 = go_cnt;
      acc(1'h1, OFS_CMD, {24'h0, r.op}, s);
      acc(1'h0, OFS_STATUS, 32'h0, s);
      check("busy", {30'h0, write_in_progress, s[BIT_WIP]}, {30'h0, b, b});
      wait_idle();
      acc(1'h0, OFS_RESULT, 32'h0, s);
      check("result", {29'h0, s[2:0]}, {29'h0, r.res});
      check("go pulses", 32'(go_cnt - g0), {31'h0, b});
      acc(1'h0, OFS_STATUS, 32'h0, s);
      check("latch", {31'h0, s[BIT_WEL]}, 32'h0);
      if (r.op == OP_STATUS_WRITE_CMD && b) begin
         // security locks are sticky, so they stay in the expectation
         sec_exp = sec_exp | (r.sr & 32'h0000_1800);
         check("status", s & SR_MASK, r.sr | sec_exp);
      end
   endtask : op
   task automatic rst();
      @(posedge pclk);
      presetn <= 1'h0;
      repeat (16) @(posedge pclk);
      presetn <= 1'h1;
      sec_exp = 32'h0;
   endtask : rst
   task automatic status_write_cmd(input logic [31:0] sr, input fwp_result_t res);
      op('{1'h1, OP_STATUS_WRITE_CMD, sr, 20'h0, res});
   endtask : status_write_cmd
   initial begin
      #1ms;
      fails++;
      summarize();
   end
   initial begin
      rst();
      acc(1'h0, OFS_STATUS, 32'h0, v);
      check("reset status", v, 32'h0);
      check("reset quad", {31'h0, quad_enable}, 32'h0);
      $display("test reset done");
      foreach (rows[i]) op(rows[i]);
      $display("test table done");
      wp_pin_n <= 1'h0;
      status_write_cmd(32'h0, RES_DONE);
      status_write_cmd(32'h80, RES_DONE);
      status_write_cmd(32'h80, RES_LOCKED);
      wp_pin_n <= 1'h1;
      status_write_cmd(32'h200, RES_DONE);
      check("quad", {31'h0, quad_enable}, 32'h1);
      status_write_cmd(32'h100, RES_DONE);
      status_write_cmd(32'h0, RES_LOCKED);
      rst();
      acc(1'h0, OFS_STATUS, 32'h0, v);
      check("power cycle", v, 32'h0);
      status_write_cmd(32'h180, RES_DONE);
      status_write_cmd(32'h0, RES_LOCKED);
      rst();
      $display("test lock modes done");
      status_write_cmd(32'h800, RES_DONE);
      status_write_cmd(32'h1000, RES_DONE);
      status_write_cmd(32'h0, RES_DONE);
      op('{1'h1, OP_SEC_PROG, 32'h0, 20'h01000, RES_PROTECTED});
      op('{1'h1, OP_SEC_ERASE, 32'h0, 20'h00000, RES_PROTECTED});
      status_write_cmd(32'h0004_0000, RES_DONE);
      op('{1'h1, OP_PP, 32'h0, 20'h10000, RES_PROTECTED});
      $display("test security locks done");
      cmd(OP_DPD);
      check("deep pd", {31'h0, deep_power_down}, 32'h1);
      op('{1'h1, OP_PP, 32'h0, 20'h0, RES_IGNORED});
      cmd(OP_WAKE);
      check("wake", {31'h0, deep_power_down}, 32'h0);
      cmd(OP_DPD);
      cmd(OP_RST_EN);
      cmd(OP_RST);
      check("reset wakes", {31'h0, deep_power_down}, 32'h0);
      cmd(OP_WRITE_ENABLE_CMD);
      acc(1'h0, OFS_STATUS, 32'h0, v);
      check("latch set", {31'h0, v[BIT_WEL]}, 32'h1);
      cmd(OP_RST_EN);
      cmd(OP_RST);
      acc(1'h0, OFS_STATUS, 32'h0, v);
      check("sw reset", v & 32'h0000_1802, 32'h0000_1800);
      cmd(OP_WRITE_ENABLE_CMD);
      cmd(OP_WRITE_DISABLE_CMD);
      acc(1'h0, OFS_STATUS, 32'h0, v);
      check("write disable", {31'h0, v[BIT_WEL]}, 32'h0);
      $display("test power-down and reset done");
      host_u.xfer(1'h0, 12'h0FC, 32'h0, v, sec_exp[0], sec_exp[1]);
      check("unmapped", {30'h0, sec_exp[1:0]}, 32'h3);
      $display("test unmapped done");
      summarize();
   end
endmodule : flash_write_protection_logic_tb

// ==== dv/fwp_host_model.sv ====
// apb master standing in for the host flash controller
// assumes the slave raises pready within a bounded number of cycles
`timescale 1ns/1ps
module fwp_host_model (
   // clock
   input wire logic pclk,
   // apb master side
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [fwp_pkg::PADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr
);
   import fwp_pkg::*;
   initial begin
      psel = 1'h0;
      penable = 1'h0;
      pwrite = 1'h0;
      paddr = '0;
      pwdata = '0;
   end
   // quad enable is only ever set here with the protect pin driven, never tied
   task automatic xfer(input logic wr, input logic [11:0] addr, input logic [31:0] wd,
         output logic [31:0] rd, output logic err, output logic ok);
      int n;
      @(posedge pclk);
      psel <= 1'h1;
      penable <= 1'h0;
      pwrite <= wr;
      paddr <= addr;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'h1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'h1 && n < 50);
      ok = (pready === 1'h1);
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      // released lines show the inverse so nothing leans on a stale value
      paddr <= ~addr;
      pwdata <= ~wd;
   endtask : xfer
endmodule : fwp_host_model

// ==== shared/fwp_pkg.sv ====
// constants for the flash write-protection and status-control block
// assumes an APB master on pclk; presetn low stands for a power-down/power-up cycle
package fwp_pkg;
   localparam int ADDR_W = 20;
   localparam int PADDR_W = 12;
   // register byte offsets
   localparam logic [11:0] OFS_STATUS = 12'h000;
   localparam logic [11:0] OFS_SR_DATA = 12'h004;
   localparam logic [11:0] OFS_TARGET = 12'h008;
   localparam logic [11:0] OFS_CMD = 12'h00C;
   localparam logic [11:0] OFS_RESULT = 12'h010;
   // status word bit positions
   localparam int BIT_WIP = 0;
   localparam int BIT_WEL = 1;
   localparam int BIT_BP_LO = 2;
   localparam int BIT_LOCK_LO = 7;
   localparam int BIT_LOCK_HI = 8;
   localparam int BIT_QE = 9;
   localparam int BIT_SEC_A = 11;
   localparam int BIT_SEC_B = 12;
   localparam int BIT_CMP = 14;
   localparam int BIT_WPS = 18;
   // reset values
   localparam logic RST_CMP = 1'b0;
   localparam logic RST_QE = 1'b0;
   localparam logic RST_WPS = 1'b0;
   localparam logic [1:0] RST_SEC = 2'h0;
   localparam logic [1:0] RST_LOCK = 2'h0;
   localparam logic [4:0] RST_BP = 5'h00;
   // status lock modes
   localparam logic [1:0] LOCK_SW = 2'h0;
   localparam logic [1:0] LOCK_HW = 2'h1;
   localparam logic [1:0] LOCK_PWR = 2'h2;
   localparam logic [1:0] LOCK_OTP = 2'h3;
   // opcodes
   localparam logic [7:0] OP_WRITE_ENABLE_CMD = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE_CMD = 8'h04;
   localparam logic [7:0] OP_STATUS_WRITE_CMD = 8'h01;
   localparam logic [7:0] OP_PP = 8'h02;
   localparam logic [7:0] OP_SE = 8'h20;
   localparam logic [7:0] OP_BE32 = 8'h52;
   localparam logic [7:0] OP_BE64 = 8'hD8;
   localparam logic [7:0] OP_CE_A = 8'hC7;
   localparam logic [7:0] OP_CE_B = 8'h60;
   localparam logic [7:0] OP_DPD = 8'hB9;
   localparam logic [7:0] OP_WAKE = 8'hAB;
   localparam logic [7:0] OP_RST_EN = 8'h66;
   localparam logic [7:0] OP_RST = 8'h99;
   localparam logic [7:0] OP_SEC_ERASE = 8'h44;
   localparam logic [7:0] OP_SEC_PROG = 8'h42;
   // target address bit choosing security register b
   localparam int SEC_SEL_BIT = 12;
   // erase/program unit spans, as low-address masks
   localparam logic [19:0] SPAN_PAGE = 20'h000FF;
   localparam logic [19:0] SPAN_SECT = 20'h00FFF;
   localparam logic [19:0] SPAN_B32 = 20'h07FFF;
   localparam logic [19:0] SPAN_B64 = 20'h0FFFF;
   // timing
   localparam longint CLK_PERIOD_NS = 50;
   localparam longint T_PP_NS = 350000;
   localparam longint T_SE_NS = 40000000;
   localparam longint T_BE32_NS = 120000000;
   localparam longint T_BE64_NS = 150000000;
   localparam longint T_CE_NS = 64'd2500000000;
   localparam longint T_SR_NS = 5000000;
   typedef enum logic [2:0] {
      RES_NONE, RES_DONE, RES_IGNORED, RES_LOCKED, RES_PROTECTED
   } fwp_result_t;
endpackage : fwp_pkg

// ==== src/fwp_ctrl.sv ====
// write-protection, status-control and write-enable logic of a serial flash
// assumes an APB master on pclk and an asynchronous protect pin input
`timescale 1ns/1ps
module fwp_ctrl #(
   parameter int unsigned PP_CYC = 32'(fwp_pkg::T_PP_NS / fwp_pkg::CLK_PERIOD_NS),
   parameter int unsigned SE_CYC = 32'(fwp_pkg::T_SE_NS / fwp_pkg::CLK_PERIOD_NS),
   parameter int unsigned BE32_CYC = 32'(fwp_pkg::T_BE32_NS / fwp_pkg::CLK_PERIOD_NS),
   parameter int unsigned BE64_CYC = 32'(fwp_pkg::T_BE64_NS / fwp_pkg::CLK_PERIOD_NS),
   parameter int unsigned CE_CYC = 32'(fwp_pkg::T_CE_NS / fwp_pkg::CLK_PERIOD_NS),
   parameter int unsigned SR_CYC = 32'(fwp_pkg::T_SR_NS / fwp_pkg::CLK_PERIOD_NS)
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [fwp_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // protect pin, active low, asynchronous
   input wire logic wp_pin_n,
   // state shown to the pad and array logic
   output logic quad_enable,
   output logic write_in_progress,
   output logic deep_power_down,
   output logic array_go
);
   import fwp_pkg::*;

   logic wp_meta_r, wp_sync_r;
   logic pready_r, pslverr_r, go_r;
   logic [31:0] prdata_r;
   logic [31:0] sr_data_r;
   logic [ADDR_W-1:0] target_r;
   logic cmp_r, qe_r, wps_r, wel_r, wip_r, dpd_r, rst_arm_r;
   logic [1:0] sec_r, lock_r;
   logic [4:0] bp_r;
   logic [31:0] busy_cnt_r, busy_nxt;
   fwp_result_t result_r, result_nxt;
   logic [31:0] status_word;
   logic wr_en, cmd_go, idle;
   logic [7:0] op;
   logic wel_set, wel_clr, sr_load, dpd_set, dpd_clr, arm_nxt, soft_rst, launch;
   logic [31:0] launch_cyc;
   logic [ADDR_W-1:0] first_a, last_a, span;
   logic is_array_op, is_ce, region_hit, ce_ok, sr_ok, sec_lock;

   // protect pin crosses into pclk through two flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wp_meta_r <= 1'b1;
         wp_sync_r <= 1'b1;
      end else begin
         wp_meta_r <= wp_pin_n;
         wp_sync_r <= wp_meta_r;
      end
   end

   // apb: zero-wait answer, registered in the setup cycle
   assign wr_en = psel & penable & pwrite & pready_r;
   assign cmd_go = wr_en & (paddr == OFS_CMD);
   assign op = pwdata[7:0];

   always_comb begin
      status_word = 32'h0;
      status_word[BIT_WIP] = wip_r;
      status_word[BIT_WEL] = wel_r;
      status_word[BIT_BP_LO +: 5] = bp_r;
      status_word[BIT_LOCK_LO] = lock_r[0];
      status_word[BIT_LOCK_HI] = lock_r[1];
      status_word[BIT_QE] = qe_r;
      status_word[BIT_SEC_A] = sec_r[0];
      status_word[BIT_SEC_B] = sec_r[1];
      status_word[BIT_CMP] = cmp_r;
      status_word[BIT_WPS] = wps_r;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
      end else if (psel && !penable && !pready_r) begin
         pready_r <= 1'b1;
         pslverr_r <= 1'b0;
         prdata_r <= 32'h0;
         unique case (paddr)
            OFS_STATUS: prdata_r <= status_word;
            OFS_SR_DATA: prdata_r <= sr_data_r;
            OFS_TARGET: prdata_r <= {{(32-ADDR_W){1'b0}}, target_r};
            OFS_CMD: prdata_r <= 32'h0;
            OFS_RESULT: prdata_r <= {27'h0, dpd_r, rst_arm_r, 3'(result_r)};
            default: pslverr_r <= 1'b1;
         endcase
      end else begin
         pready_r <= 1'b0;
         pslverr_r <= 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sr_data_r <= 32'h0;
         target_r <= '0;
      end else begin
         if (wr_en && paddr == OFS_SR_DATA) begin
            sr_data_r <= pwdata;
         end
         if (wr_en && paddr == OFS_TARGET) begin
            target_r <= pwdata[ADDR_W-1:0];
         end
      end
   end

   // region decode for scheme 0, complement 0; readable regardless of result
   function automatic logic in_region(input logic [ADDR_W-1:0] a, input logic [4:0] bp);
      logic [2:0] n;
      logic [4:0] lg;
      logic [ADDR_W-1:0] mask;
      logic all_hit;
      logic hit;
      n = bp[2:0];
      lg = 5'd0;
      all_hit = 1'b0;
      if (!bp[4]) begin
         if (n >= 3'd5) all_hit = 1'b1;
         else lg = 5'd15 + {2'b00, n};
      end else begin
         if (n[2:1] == 2'b11) all_hit = 1'b1;
         else if (n[2]) lg = 5'd15;
         else lg = 5'd11 + {2'b00, n};
      end
      mask = 20'hFFFFF << lg;
      hit = all_hit | (bp[3] ? ((a & mask) == 20'h0) : ((a & mask) == mask));
      if (n == 3'b000) hit = 1'b0;
      return hit;
   endfunction : in_region

   always_comb begin
      unique case (op)
         OP_PP: span = SPAN_PAGE;
         OP_SE: span = SPAN_SECT;
         OP_BE32: span = SPAN_B32;
         default: span = SPAN_B64;
      endcase
   end
   assign first_a = target_r & ~span;
   assign last_a = target_r | span;
   assign is_ce = (op == OP_CE_A) || (op == OP_CE_B);
   assign is_array_op = (op == OP_PP) || (op == OP_SE) || (op == OP_BE32) || (op == OP_BE64);
   // scheme 1 locks all blocks after reset, complement 1 decode not held: both refuse
   assign region_hit = wps_r | cmp_r | in_region(first_a, bp_r) | in_region(last_a, bp_r);
   assign ce_ok = !wps_r && ((!cmp_r && bp_r[2:0] == 3'b000) ||
      (cmp_r && bp_r[2:0] == 3'b111));
   assign sr_ok = (lock_r == LOCK_SW) || (lock_r == LOCK_HW && wp_sync_r);
   assign sec_lock = target_r[SEC_SEL_BIT] ? sec_r[1] : sec_r[0];
   assign idle = !wip_r;

   // command decision
   always_comb begin
      wel_set = 1'b0;
      wel_clr = 1'b0;
      sr_load = 1'b0;
      dpd_set = 1'b0;
      dpd_clr = 1'b0;
      soft_rst = 1'b0;
      launch = 1'b0;
      launch_cyc = 32'h0;
      arm_nxt = rst_arm_r;
      result_nxt = result_r;
      if (cmd_go) begin
         arm_nxt = 1'b0;
         result_nxt = RES_IGNORED;
         if (op == OP_RST_EN) begin
            arm_nxt = 1'b1;
            result_nxt = RES_DONE;
         end else if (op == OP_RST && rst_arm_r) begin
            soft_rst = 1'b1;
            result_nxt = RES_DONE;
         end else if (dpd_r) begin
            if (op == OP_WAKE) begin
               dpd_clr = 1'b1;
               result_nxt = RES_DONE;
            end
         end else if (!idle) begin
            result_nxt = RES_IGNORED;
         end else if (op == OP_WRITE_ENABLE_CMD) begin
            wel_set = 1'b1;
            result_nxt = RES_DONE;
         end else if (op == OP_WRITE_DISABLE_CMD) begin
            wel_clr = 1'b1;
            result_nxt = RES_DONE;
         end else if (op == OP_DPD) begin
            dpd_set = 1'b1;
            result_nxt = RES_DONE;
         end else if (!wel_r) begin
            result_nxt = RES_IGNORED;
         end else if (op == OP_STATUS_WRITE_CMD) begin
            wel_clr = 1'b1;
            if (sr_ok) begin
               sr_load = 1'b1;
               launch = 1'b1;
               launch_cyc = SR_CYC;
               result_nxt = RES_DONE;
            end else begin
               result_nxt = RES_LOCKED;
            end
         end else if (is_array_op || is_ce) begin
            wel_clr = 1'b1;
            if (is_ce ? !ce_ok : region_hit) begin
               result_nxt = RES_PROTECTED;
            end else begin
               launch = 1'b1;
               result_nxt = RES_DONE;
               unique case (1'b1)
                  is_ce: launch_cyc = CE_CYC;
                  op == OP_PP: launch_cyc = PP_CYC;
                  op == OP_SE: launch_cyc = SE_CYC;
                  op == OP_BE32: launch_cyc = BE32_CYC;
                  default: launch_cyc = BE64_CYC;
               endcase
            end
         end else if (op == OP_SEC_ERASE || op == OP_SEC_PROG) begin
            wel_clr = 1'b1;
            if (sec_lock) begin
               result_nxt = RES_PROTECTED;
            end else begin
               launch = 1'b1;
               launch_cyc = (op == OP_SEC_ERASE) ? SE_CYC : PP_CYC;
               result_nxt = RES_DONE;
            end
         end
      end
   end

   always_comb begin
      if (soft_rst) busy_nxt = 32'h0;
      else if (launch) busy_nxt = launch_cyc;
      else if (busy_cnt_r != 32'h0) busy_nxt = busy_cnt_r - 32'h1;
      else busy_nxt = 32'h0;
   end

   // busy tracking; refused operations never load the counter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_cnt_r <= 32'h0;
         wip_r <= 1'b0;
         go_r <= 1'b0;
      end else begin
         busy_cnt_r <= busy_nxt;
         wip_r <= (busy_nxt != 32'h0);
         go_r <= launch;
      end
   end

   // latch set wins only over nothing: set and clear never come together
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wel_r <= 1'b0;
      end else if (soft_rst || wel_clr) begin
         wel_r <= 1'b0;
      end else if (wel_set) begin
         wel_r <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dpd_r <= 1'b0;
         rst_arm_r <= 1'b0;
         result_r <= RES_NONE;
      end else begin
         rst_arm_r <= arm_nxt;
         result_r <= result_nxt;
         if (soft_rst || dpd_clr) dpd_r <= 1'b0;
         else if (dpd_set) dpd_r <= 1'b1;
      end
   end

   // non-volatile bits; presetn stands for the power cycle, so lock mode 10 leaves here
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_r <= RST_CMP;
         qe_r <= RST_QE;
         wps_r <= RST_WPS;
         sec_r <= RST_SEC;
         lock_r <= RST_LOCK;
         bp_r <= RST_BP;
      end else if (sr_load) begin
         cmp_r <= sr_data_r[BIT_CMP];
         qe_r <= sr_data_r[BIT_QE];
         wps_r <= sr_data_r[BIT_WPS];
         sec_r <= sec_r | {sr_data_r[BIT_SEC_B], sr_data_r[BIT_SEC_A]};
         lock_r <= sr_data_r[BIT_LOCK_HI:BIT_LOCK_LO];
         bp_r <= sr_data_r[BIT_BP_LO +: 5];
      end
   end

   assign prdata = prdata_r;
   assign pready = pready_r;
   assign pslverr = pslverr_r;
   assign quad_enable = qe_r;
   assign write_in_progress = wip_r;
   assign deep_power_down = dpd_r;
   assign array_go = go_r;

   logic sr_try;
   assign sr_try = cmd_go && op == OP_STATUS_WRITE_CMD && wel_r && idle && !dpd_r && !rst_arm_r;

   a_wel_gate: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_go && !wel_r && !dpd_r && (is_array_op || op == OP_STATUS_WRITE_CMD)
      |=> result_r == RES_IGNORED && !go_r && $stable(bp_r))
      else $error("command taken with latch clear");
   a_sw_mode: assert property (@(posedge pclk) disable iff (!presetn)
      sr_try && lock_r == LOCK_SW |=> result_r == RES_DONE && wip_r && !wel_r)
      else $error("status write refused in software mode");
   a_hw_locked: assert property (@(posedge pclk) disable iff (!presetn)
      sr_try && lock_r == LOCK_HW && !wp_sync_r |=> result_r == RES_LOCKED && $stable(bp_r))
      else $error("status write taken with protect pin low");
   a_hw_open: assert property (@(posedge pclk) disable iff (!presetn)
      sr_try && lock_r == LOCK_HW && wp_sync_r |=> result_r == RES_DONE && wip_r && !wel_r)
      else $error("status write refused with protect pin high");
   a_power_lock: assert property (@(posedge pclk) disable iff (!presetn)
      sr_try && lock_r == LOCK_PWR |=> result_r == RES_LOCKED && lock_r == LOCK_PWR)
      else $error("power lock mode let a status write through");
   a_otp_lock: assert property (@(posedge pclk) disable iff (!presetn)
      lock_r == LOCK_OTP |=> lock_r == LOCK_OTP)
      else $error("one-time lock mode left");
   a_sec_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      sec_r[0] ##1 1 |-> sec_r[0])
      else $error("security lock cleared");
   a_prot_refuse: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_go && wel_r && idle && !dpd_r && !rst_arm_r && is_array_op && region_hit
      |=> result_r == RES_PROTECTED)
      else $error("protected region operation not refused");
   a_refuse_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      result_r == RES_PROTECTED && $changed(result_r) |-> !go_r && !wip_r [*2])
      else $error("refused operation went busy");
   a_wel_set: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_go && op == OP_WRITE_ENABLE_CMD && idle && !dpd_r && !rst_arm_r |=> wel_r)
      else $error("write enable did not set latch");
   a_dpd_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_go && dpd_r && op == OP_WRITE_ENABLE_CMD |=> $stable(wel_r) && dpd_r)
      else $error("command acted in deep power-down");
   a_busy_bit: assert property (@(posedge pclk) disable iff (!presetn)
      go_r |-> wip_r && status_word[BIT_WIP])
      else $error("busy bit low while operating");
   a_chip_erase: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_go && is_ce && wel_r && idle && !dpd_r && !wps_r && cmp_r &&
      bp_r[2:0] == 3'h7 |=> result_r == RES_DONE && go_r)
      else $error("chip erase refused with all bits and complement set");
   a_wel_clear: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_go && op == OP_WRITE_DISABLE_CMD && idle && !dpd_r |=> !wel_r)
      else $error("write disable left latch set");
   a_sec_b_sticky: assert property (@(posedge pclk) disable iff (!presetn)
      sec_r[1] |=> sec_r[1])
      else $error("security lock b cleared");
   a_bp_hold: assert property (@(posedge pclk) disable iff (!presetn)
      cmd_go && op == OP_STATUS_WRITE_CMD && !sr_ok |=> $stable(bp_r))
      else $error("block protect changed while status locked");
   a_top_region: assert property (@(posedge pclk) disable iff (!presetn)
      !wps_r && !cmp_r && bp_r == 5'h01 && target_r[19:16] == 4'hF |-> region_hit)
      else $error("upper sixteenth not decoded as protected");

   c_sr_done: cover property (@(posedge pclk) disable iff (!presetn)
      sr_try ##1 result_r == RES_DONE);
   c_prot: cover property (@(posedge pclk) disable iff (!presetn)
      result_r == RES_PROTECTED);
   c_soft_rst: cover property (@(posedge pclk) disable iff (!presetn) soft_rst);
   c_chip_erase: cover property (@(posedge pclk) disable iff (!presetn)
      cmd_go && is_ce && ce_ok && wel_r);
   c_dpd_wake: cover property (@(posedge pclk) disable iff (!presetn) dpd_clr);
endmodule : fwp_ctrl
